/* shared/sac_pkg.sv */
package sac_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL0  = 8'h00;
  localparam logic [7:0] OFS_CTRL1  = 8'h04;
  localparam logic [7:0] OFS_CTRL2  = 8'h08;
  localparam logic [7:0] OFS_RES_HI = 8'h0c;
  localparam logic [7:0] OFS_RES_LO = 8'h10;
  localparam logic [7:0] OFS_STAT   = 8'h14;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CH_LSB    = 2;
  localparam int GO_BIT    = 1;
  localparam int ON_BIT    = 0;
  localparam int NREF_BIT  = 5;
  localparam int PREF_BIT  = 4;
  localparam int JUST_BIT  = 7;
  localparam int ACQ_LSB   = 3;
  localparam int DONE_BIT  = 0;
  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [3:0] PCFG_FUSE1 = 4'h0;
  localparam logic [3:0] PCFG_FUSE0 = 4'h7;
  localparam logic [3:0] CH_LAST    = 4'ha;
  localparam logic [3:0] PCFG_TOP   = 4'hf;
  localparam logic [9:0] FULL_SCALE = 10'h3ff;
  localparam logic [9:0] SAR_MSB    = 10'h200;
  localparam logic [3:0] CONV_TADS  = 4'hb;
  localparam logic [1:0] RESP_OK    = 2'h0;
  localparam logic [1:0] RESP_ERR   = 2'h2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS     = 4;
  localparam int TCY_OSC    = 4;
  localparam int TCY_CYC    = TCY_OSC;
  localparam int RC_TAD_NS  = 1200;
  localparam int RC_TAD_CYC = RC_TAD_NS / CLK_NS;
endpackage : sac_pkg

/* rtl/sac_tad_gen.sv */
`timescale 1ns/1ps
module sac_tad_gen (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [2:0] clk_sel,
  input  wire logic       sleep_mode,
  output logic            tad_tick
);
  // ---------------------------------------------------------------
  // period select
  // ---------------------------------------------------------------
  logic [15:0] cnt_reg;
  logic [15:0] dly_reg;
  logic [15:0] period;
  wire         is_rc = (clk_sel[1:0] == 2'h3);
  wire         clk_ok = is_rc || !sleep_mode;
  wire         cnt_wrap = (cnt_reg == period - 16'h1);

  always_comb begin
    case (clk_sel)
      3'h0:    period = 16'h2;
      3'h1:    period = 16'h8;
      3'h2:    period = 16'h20;
      3'h4:    period = 16'h4;
      3'h5:    period = 16'h10;
      3'h6:    period = 16'h40;
      default: period = 16'(sac_pkg::RC_TAD_CYC);
    endcase
  end

  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_reg  <= 16'h0;
      dly_reg  <= is_rc && aresetn ? 16'(sac_pkg::TCY_CYC) : 16'h0;
      tad_tick <= 1'b0;
    end else if (dly_reg != 16'h0) begin
      dly_reg  <= dly_reg - 16'h1;
      tad_tick <= 1'b0;
    end else if (clk_ok) begin
      cnt_reg  <= cnt_wrap ? 16'h0 : cnt_reg + 16'h1;
      tad_tick <= cnt_wrap;
    end else begin
      tad_tick <= 1'b0;
    end
  end

  rc_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(run) && is_rc |-> !tad_tick [*5])
    else $error("rc clock started without delay");
endmodule : sac_tad_gen

/* rtl/sac_ctrl.sv */
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - ctrl0 bits 5..2 pick channel; codes 0..10 inputs, 11..15 unused.
// - unimplemented channel converts to full-scale result.
// - status bit 1 reads one while converting, zero when idle.
// - bit 0 of ctrl0 turns converter on or off.
// - ctrl1 bit 5 picks external negative reference or analog ground.
// - ctrl1 bit 4 picks external positive reference or analog supply.
// - pin codes 0..4 all analog; each higher code digitises from input 10.
// - reset loads pin config 0 if fuse set, 7 if fuse clear.
// - ctrl2 bit 7 selects right or left justified result.
// - acquisition codes give 0,2,4,6,8,12,16,20 conversion clock periods.
// - clock codes pick system clock /2,/8,/32,/4,/16,/64 or RC.
// - RC clock starts one instruction cycle after start.
// - only RC clock keeps converting in sleep; software picks it.
// - sample-hold output converted by successive-approximation search.
// - reset restores control and status registers, turns module off, aborts conversion.
// - end of conversion loads result, clears status, sets done flag.
// - result registers keep contents across reset.
// - nonzero acquisition time samples that long after start, then converts
// - unimplemented control bits read zero and ignore writes.
// - a conversion takes eleven conversion clock periods.
// - after conversion the selected channel is sampled again.
module sac_ctrl #(
  parameter logic [10:0] CHAN_PRESENT = 11'h7ff
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        analog_default_fuse,
  input  wire logic        sleep_mode,
  input  wire logic        cmp_in,
  output logic [3:0]       input_channel_select,
  output logic             negative_reference_select,
  output logic             positive_reference_select,
  output logic [10:0]      pin_analog_mask,
  output logic             sample_enable,
  output logic [9:0]       dac_code,
  output logic             conversion_done_flag
);
  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} sac_state_e;

  sac_state_e  state_reg;
  sac_state_e  state_next;
  logic        converter_on;
  logic [1:0]  ref_sel_reg;
  logic [3:0]  pin_analog_config;
  logic        result_justify;
  logic [2:0]  acquisition_time_select;
  logic [2:0]  conversion_clock_select;
  logic [9:0]  result_reg;
  logic [9:0]  sar_reg;
  logic [9:0]  mask_reg;
  logic [4:0]  acq_left_reg;
  logic [3:0]  tad_cnt_reg;
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic        w_lane0_reg;
  logic        tad_tick;
  logic [4:0]  acq_tads;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  wire       aw_now   = s_axi_awvalid && s_axi_awready;
  wire       w_now    = s_axi_wvalid && s_axi_wready;
  wire       have_aw  = aw_got_reg || aw_now;
  wire       have_w   = w_got_reg || w_now;
  wire       wr_do    = have_aw && have_w && !s_axi_bvalid;
  wire [7:0] wr_addr  = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
  wire [7:0] wr_byte  = w_got_reg ? w_data_reg[7:0] : s_axi_wdata[7:0];
  wire       wr_lane0 = w_got_reg ? w_lane0_reg : s_axi_wstrb[0];
  wire       wr_en    = wr_do && wr_lane0;
  wire       wr_ctrl0 = wr_en && (wr_addr == sac_pkg::OFS_CTRL0);
  wire       wr_ctrl1 = wr_en && (wr_addr == sac_pkg::OFS_CTRL1);
  wire       wr_ctrl2 = wr_en && (wr_addr == sac_pkg::OFS_CTRL2);
  wire       wr_stat  = wr_en && (wr_addr == sac_pkg::OFS_STAT);
  wire       wr_known = (wr_addr == sac_pkg::OFS_CTRL0) ||
                        (wr_addr == sac_pkg::OFS_CTRL1) ||
                        (wr_addr == sac_pkg::OFS_CTRL2) ||
                        (wr_addr == sac_pkg::OFS_RES_HI) ||
                        (wr_addr == sac_pkg::OFS_RES_LO) ||
                        (wr_addr == sac_pkg::OFS_STAT);

  // ---------------------------------------------------------------
  // conversion control decode
  // ---------------------------------------------------------------
  wire       on_next   = wr_ctrl0 ? wr_byte[sac_pkg::ON_BIT] : converter_on;
  wire       go_write  = wr_ctrl0 && wr_byte[sac_pkg::GO_BIT];
  wire       start     = go_write && on_next && (state_reg == ST_IDLE);
  wire       abort     = !on_next ||
                         (wr_ctrl0 && !wr_byte[sac_pkg::GO_BIT]);
  wire       busy      = (state_reg != ST_IDLE);
  wire       conv_tick = (state_reg == ST_CONV) && tad_tick;
  wire       conv_last = conv_tick &&
                         (tad_cnt_reg == sac_pkg::CONV_TADS - 4'h1);
  wire       done      = conv_last && !abort;
  wire       decide    = conv_tick && (tad_cnt_reg != 4'h0);
  wire       ch_valid  = (input_channel_select <= sac_pkg::CH_LAST) &&
                         CHAN_PRESENT[input_channel_select];
  wire [9:0] sar_dec   = cmp_in ? sar_reg : (sar_reg & ~mask_reg);
  wire [9:0] conv_val  = ch_valid ? sar_dec : sac_pkg::FULL_SCALE;

  always_comb begin
    case (acquisition_time_select)
      3'h0:    acq_tads = 5'd0;
      3'h1:    acq_tads = 5'd2;
      3'h2:    acq_tads = 5'd4;
      3'h3:    acq_tads = 5'd6;
      3'h4:    acq_tads = 5'd8;
      3'h5:    acq_tads = 5'd12;
      3'h6:    acq_tads = 5'd16;
      default: acq_tads = 5'd20;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = (acq_tads == 5'd0) ? ST_CONV : ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (tad_tick && acq_left_reg == 5'd1) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_last) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (abort) begin
      state_next = ST_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // conversion clock
  // ---------------------------------------------------------------
  sac_tad_gen u_tad (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .run        (busy),
    .clk_sel    (conversion_clock_select),
    .sleep_mode (sleep_mode),
    .tad_tick   (tad_tick)
  );

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_on            <= 1'b0;
      input_channel_select    <= 4'h0;
      ref_sel_reg             <= 2'h0;
      pin_analog_config       <= analog_default_fuse ?
                                 sac_pkg::PCFG_FUSE1 :
                                 sac_pkg::PCFG_FUSE0;
      result_justify          <= 1'b0;
      acquisition_time_select <= 3'h0;
      conversion_clock_select <= 3'h0;
    end else begin
      if (wr_ctrl0) begin
        converter_on         <= wr_byte[sac_pkg::ON_BIT];
        input_channel_select <= wr_byte[sac_pkg::CH_LSB +: 4];
      end
      if (wr_ctrl1) begin
        ref_sel_reg       <= wr_byte[sac_pkg::PREF_BIT +: 2];
        pin_analog_config <= wr_byte[3:0];
      end
      if (wr_ctrl2) begin
        result_justify          <= wr_byte[sac_pkg::JUST_BIT];
        acquisition_time_select <= wr_byte[sac_pkg::ACQ_LSB +: 3];
        conversion_clock_select <= wr_byte[2:0];
      end
    end
  end

  assign negative_reference_select = ref_sel_reg[1];
  assign positive_reference_select = ref_sel_reg[0];

  // ---------------------------------------------------------------
  // pin configuration per input
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 11; gi++) begin : g_pin
      always_ff @(posedge aclk) begin
        pin_analog_mask[gi] <= (5'(gi) <
          (5'(sac_pkg::PCFG_TOP) - 5'(pin_analog_config)));
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // sequencer and successive approximation
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg            <= ST_IDLE;
      acq_left_reg         <= 5'd0;
      tad_cnt_reg          <= 4'h0;
      sar_reg              <= sac_pkg::SAR_MSB;
      mask_reg             <= sac_pkg::SAR_MSB;
      sample_enable        <= 1'b0;
      conversion_done_flag <= 1'b0;
    end else begin
      state_reg     <= state_next;
      sample_enable <= on_next && (state_next != ST_CONV);
      if (start) begin
        acq_left_reg <= acq_tads;
      end else if (tad_tick && state_reg == ST_ACQ) begin
        acq_left_reg <= acq_left_reg - 5'd1;
      end
      if (state_reg != ST_CONV) begin
        tad_cnt_reg <= 4'h0;
        sar_reg     <= sac_pkg::SAR_MSB;
        mask_reg    <= sac_pkg::SAR_MSB;
      end else if (conv_tick) begin
        tad_cnt_reg <= tad_cnt_reg + 4'h1;
        if (decide) begin
          sar_reg  <= sar_dec | (mask_reg >> 1);
          mask_reg <= mask_reg >> 1;
        end
      end
      if (done) begin
        conversion_done_flag <= 1'b1;
      end else if (wr_stat && wr_byte[sac_pkg::DONE_BIT]) begin
        conversion_done_flag <= 1'b0;
      end
    end
  end

  assign dac_code = sar_reg;

  // no reset: contents survive reset
  always_ff @(posedge aclk) begin
    if (done) begin
      result_reg <= conv_val;
    end
  end

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  wire [7:0] res_hi  = result_justify ? {6'h0, result_reg[9:8]} :
                       result_reg[9:2];
  wire [7:0] res_lo  = result_justify ? result_reg[7:0] :
                       {result_reg[1:0], 6'h0};
  wire [7:0] rd_ctrl0 = {2'h0, input_channel_select, busy,
                         converter_on};
  wire [7:0] rd_ctrl1 = {2'h0, ref_sel_reg, pin_analog_config};
  wire [7:0] rd_ctrl2 = {result_justify, 1'b0, acquisition_time_select,
                         conversion_clock_select};
  logic [7:0] rd_byte;
  logic       rd_known;

  always_comb begin
    rd_known = 1'b1;
    case (s_axi_araddr)
      sac_pkg::OFS_CTRL0:  rd_byte = rd_ctrl0;
      sac_pkg::OFS_CTRL1:  rd_byte = rd_ctrl1;
      sac_pkg::OFS_CTRL2:  rd_byte = rd_ctrl2;
      sac_pkg::OFS_RES_HI: rd_byte = res_hi;
      sac_pkg::OFS_RES_LO: rd_byte = res_lo;
      sac_pkg::OFS_STAT:   rd_byte = {7'h0, conversion_done_flag};
      default: begin
        rd_byte  = 8'h0;
        rd_known = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_addr_reg   <= 8'h0;
      w_data_reg    <= 32'h0;
      w_lane0_reg   <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sac_pkg::RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= sac_pkg::RESP_OK;
    end else begin
      if (aw_now) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_now) begin
        w_data_reg  <= s_axi_wdata;
        w_lane0_reg <= s_axi_wstrb[0];
      end
      aw_got_reg    <= have_aw && !wr_do;
      w_got_reg     <= have_w && !wr_do;
      s_axi_awready <= !have_aw && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !have_w && !s_axi_wready && !s_axi_bvalid;
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? sac_pkg::RESP_OK : sac_pkg::RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h0, rd_byte};
        s_axi_rresp  <= rd_known ? sac_pkg::RESP_OK : sac_pkg::RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [4:0] tick_seen;
  always_ff @(posedge aclk) begin
    if (!aresetn || state_reg != ST_CONV) begin
      tick_seen <= 5'd0;
    end else if (tad_tick) begin
      tick_seen <= tick_seen + 5'd1;
    end
  end

  conv_length_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    done |-> tick_seen == 5'd10)
    else $error("conversion not eleven periods");

  done_effects_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    done |=> conversion_done_flag && !busy && result_reg == $past(conv_val))
    else $error("end of conversion effects missing");

  status_busy_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    start |=> rd_ctrl0[sac_pkg::GO_BIT])
    else $error("status bit not set after start");

  off_abort_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !converter_on |-> !busy && !sample_enable)
    else $error("converter active while off");

  reset_off_a: assert property (@(posedge aclk)
    !aresetn |=> state_reg == ST_IDLE && !converter_on)
    else $error("reset did not stop converter");

  acq_wait_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    start && acq_tads != 5'd0 |=> state_reg == ST_ACQ [*2])
    else $error("conversion began before acquisition");

  full_scale_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    done && !ch_valid |=> result_reg == sac_pkg::FULL_SCALE)
    else $error("unimplemented channel not full scale");

  unimpl_zero_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 &&
      (rd_ctrl0[7:6] == 2'h0) && rd_ctrl2[6] == 1'b0)
    else $error("unimplemented bits not zero");

  resample_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    done && converter_on && !abort |=> ##1 sample_enable)
    else $error("sampling not resumed");
endmodule : sac_ctrl

/* bench/sac_cmp_model.sv */
`timescale 1ns/1ps
module sac_cmp_model (
  input  wire logic       aclk,
  input  wire logic       sample_enable,
  input  wire logic [9:0] dac_code,
  input  wire logic [9:0] vin,
  output logic            cmp_in
);
  // held level, frozen while the converter is not sampling
  logic [9:0] held_reg = 10'h000;

  always_ff @(posedge aclk) begin
    if (sample_enable) held_reg <= vin;
  end

  assign cmp_in = (held_reg >= dac_code);
endmodule : sac_cmp_model

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        analog_default_fuse = 1'b1;
  logic        sleep_mode = 1'b0;
  logic [9:0]  vin = 10'h000;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, cmp_in;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdat;
  logic [3:0]  input_channel_select;
  logic        negative_reference_select, positive_reference_select;
  logic        sample_enable, conversion_done_flag;
  logic [10:0] pin_analog_mask;
  logic [9:0]  dac_code;
  localparam logic [10:0] CH_OK = 11'h71f;
  int tad_tab [8] = '{2, 8, 32, sac_pkg::RC_TAD_CYC, 4, 16, 64,
                      sac_pkg::RC_TAD_CYC};
  wire [1:0]  refs = {negative_reference_select, positive_reference_select};
  wire [31:0] pmask = {21'h0, pin_analog_mask};
  logic [9:0] exp_r;
  int acq_tab [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  logic [9:0] vin_tab [8] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa,
                              10'h001, 10'h0f0, 10'h200, 10'h1ff};
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #2 aclk = ~aclk;

  sac_ctrl #(.CHAN_PRESENT(CH_OK)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .analog_default_fuse, .sleep_mode, .cmp_in, .input_channel_select,
    .negative_reference_select, .positive_reference_select,
    .pin_analog_mask, .sample_enable, .dac_code, .conversion_done_flag);

  sac_cmp_model partner (.aclk, .sample_enable, .dac_code, .vin, .cmp_in);

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic check_in(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[FAIL] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : check_in

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg

  // ---------------------------------------------------------------
  // one conversion: clock code and acquisition code both i
  // ---------------------------------------------------------------
  task automatic conv(input int i, input logic j, input logic [3:0] ch,
                      input logic [9:0] v, input logic [9:0] r);
    int t0;
    int ex;
    int lo;
    int hi;
    ex = (acq_tab[i] + 11) * tad_tab[i] +
         ((i % 4 == 3) ? sac_pkg::TCY_CYC : 0);
    lo = ex - tad_tab[i];
    hi = ex + tad_tab[i] + 8;
    vin <= v;
    wr_reg(sac_pkg::OFS_CTRL2, {j, 1'b0, i[2:0], i[2:0]});
    wr_reg(sac_pkg::OFS_CTRL0, {2'b00, ch, 2'b01});
    wr_reg(sac_pkg::OFS_STAT, 8'h01);
    check({28'h0, input_channel_select}, {28'h0, ch});
    repeat (2 * tad_tab[i]) @(posedge aclk);
    wr_reg(sac_pkg::OFS_CTRL0, {2'b00, ch, 2'b11});
    t0 = cyc;
    rd_reg(sac_pkg::OFS_CTRL0);
    check(rdat, {26'h0, ch, 2'b11});
    while (conversion_done_flag !== 1'b1) @(posedge aclk);
    check_in(cyc - t0, lo, hi);
    rd_reg(sac_pkg::OFS_CTRL0);
    check(rdat, {26'h0, ch, 2'b01});
    check({31'h0, sample_enable}, 32'h1);
    rd_reg(sac_pkg::OFS_RES_HI);
    check(rdat, j ? {30'h0, r[9:8]} : {24'h0, r[9:2]});
    rd_reg(sac_pkg::OFS_RES_LO);
    check(rdat, j ? {24'h0, r[7:0]} : {24'h0, r[1:0], 6'h00});
  endtask : conv

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(sac_pkg::OFS_CTRL0);
    check(rdat, 32'h0);
    rd_reg(sac_pkg::OFS_CTRL1);
    check(rdat, 32'h0);
    rd_reg(8'h18);
    check({30'h0, rsp}, {30'h0, sac_pkg::RESP_ERR});
    for (int c = 0; c < 16; c++) begin
      wr_reg(sac_pkg::OFS_CTRL1, {4'hf, c[3:0]});
      repeat (2) @(posedge aclk);
      check(pmask, (c <= 4) ? 32'h7ff : 32'h7ff >> (c - 4));
    end
    rd_reg(sac_pkg::OFS_CTRL1);
    check(rdat, 32'h3f);
    check({30'h0, refs}, 32'h3);
    wr_reg(sac_pkg::OFS_CTRL1, 8'h20);
    repeat (2) @(posedge aclk);
    check({30'h0, refs}, 32'h2);
    wr_reg(sac_pkg::OFS_CTRL2, 8'hff);
    rd_reg(sac_pkg::OFS_CTRL2);
    check(rdat, 32'hbf);
    wr_reg(8'h18, 8'h01);
    check({30'h0, rsp}, {30'h0, sac_pkg::RESP_ERR});
    for (int i = 0; i < 8; i++) begin
      sleep_mode <= (i == 3);
      exp_r = CH_OK[i] ? vin_tab[i] : sac_pkg::FULL_SCALE;
      conv(i, i[0], i[3:0], vin_tab[i], exp_r);
    end
    sleep_mode <= 1'b0;
    conv(0, 1'b1, 4'hb, 10'h0a5, 10'h3ff);
    wr_reg(sac_pkg::OFS_STAT, 8'h01);
    wr_reg(sac_pkg::OFS_CTRL2, 8'h06);
    wr_reg(sac_pkg::OFS_CTRL0, 8'h03);
    wr_reg(sac_pkg::OFS_CTRL0, 8'h00);
    repeat (800) @(posedge aclk);
    check({31'h0, conversion_done_flag}, 32'h0);
    sleep_mode <= 1'b1;
    wr_reg(sac_pkg::OFS_CTRL0, 8'h03);
    repeat (800) @(posedge aclk);
    rd_reg(sac_pkg::OFS_CTRL0);
    check(rdat, 32'h03);
    sleep_mode <= 1'b0;
    wr_reg(sac_pkg::OFS_CTRL0, 8'h03);
    repeat (50) @(posedge aclk);
    aresetn <= 1'b0;
    analog_default_fuse <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(sac_pkg::OFS_CTRL0);
    check(rdat, 32'h0);
    check({30'h0, conversion_done_flag, sample_enable}, 32'h0);
    rd_reg(sac_pkg::OFS_CTRL1);
    check(rdat, 32'h07);
    check({21'h0, pin_analog_mask}, 32'h0ff);
    rd_reg(sac_pkg::OFS_RES_HI);
    check(rdat, 32'hff);
    rd_reg(sac_pkg::OFS_RES_LO);
    check(rdat, 32'hc0);
    conclude();
  end
endmodule : tb
